// ---- logic/overtemp_alarm_logic.sv ----
// Over-temperature alarm: set-points, configuration, conversion pacing and alarm pin
`timescale 1ns/10ps
module overtemp_alarm_logic #(
   parameter int CONV_CYCLES = ot_alarm_pkg::CONV_INTERVAL_CYC
) (
   input  wire logic                              CLOCK,
   input  wire logic                              RST_N,
   input  wire logic                              LINK_CLOCK,
   input  wire logic                              CONV_DONE,
   input  wire logic [ot_alarm_pkg::TEMP_W-1:0]   CONV_TEMP,
   output var  logic                              CONV_START,
   input  wire logic                              HOST_PTR_WE,
   input  wire logic [1:0]                        HOST_PTR,
   input  wire logic                              HOST_WE,
   input  wire logic [ot_alarm_pkg::WORD_W-1:0]   HOST_WDATA,
   input  wire logic                              HOST_RE,
   output var  logic [ot_alarm_pkg::WORD_W-1:0]   HOST_RDATA,
   output var  logic                              HOST_BUSY,
   input  wire logic                              OVERTEMP_ALARM_OUT_LEVEL,
   output var  logic                              OVERTEMP_ALARM_OUT,
   output var  logic                              OVERTEMP_ALARM_OUT_EN
);
   import ot_alarm_pkg::*;

   localparam int CNT_W = $clog2(CONV_CYCLES + 1);

   // State on the conversion clock
   typedef struct packed {
      logic [CNT_W-1:0]   conv_cnt;
      logic               conv_start;
      logic [TEMP_W-1:0]  temp;
      logic [CFG_W-1:0]   cfg;
      logic [SP_W-1:0]    hyst;
      logic [SP_W-1:0]    upper;
      ptr_e               ptr;
      logic               hot;
      logic               alarm;
      logic [QUEUE_W-1:0] fault_cnt;
      logic               pin_en;
      logic               cmd_seq;
   } core_s;

   // State on the link clock
   typedef struct packed {
      logic               issued_seq;
      logic               seen_seq;
      logic [WORD_W-1:0]  rdata;
      logic               busy;
   } link_s;

   localparam core_s CORE_RESET = '{
      conv_cnt:   '0,
      conv_start: 1'b0,
      temp:       TEMP_RESET,
      cfg:        CONFIG_RESET,
      hyst:       HYST_RESET,
      upper:      UPPER_RESET,
      ptr:        PTR_TEMP,
      hot:        1'b0,
      alarm:      1'b0,
      fault_cnt:  '0,
      pin_en:     1'b0,
      cmd_seq:    1'b0
   };

   core_s c;
   core_s next_c;
   link_s l;
   link_s next_l;

   xfer_if #(.W(CMD_W)) cmd_ch ();
   xfer_if #(.W(RET_W)) ret_ch ();

   logic                     cmd_valid;
   logic [CMD_W-1:0]         cmd_word;
   op_e                      cmd_op;
   logic [WORD_W-1:0]        cmd_data;
   logic [WORD_W-1:0]        read_word;
   logic                     ret_busy;
   logic signed [SP_W-1:0]   reading;
   logic                     above;
   logic                     below;
   logic                     trip;
   logic [QUEUE_W-1:0]       need;
   logic [QUEUE_W-1:0]       run_len;
   logic                     any_req;
   logic                     accept;
   logic [CMD_W-1:0]         cmd_payload;
   logic                     cmd_busy;
   logic                     ret_valid;
   logic [RET_W-1:0]         ret_word;

   // Commands from the host link into the conversion domain
   xfer_tx #(.W(CMD_W)) cmd_sender (
      .clock   (LINK_CLOCK),
      .rst_n   (RST_N),
      .ch      (cmd_ch),
      .send    (accept),
      .payload (cmd_payload),
      .busy    (cmd_busy)
   );

   xfer_rx #(.W(CMD_W)) cmd_taker (
      .clock (CLOCK),
      .rst_n (RST_N),
      .ch    (cmd_ch),
      .valid (cmd_valid),
      .word  (cmd_word)
   );

   // Selected register word, refreshed toward the link whenever the channel is idle
   xfer_tx #(.W(RET_W)) ret_sender (
      .clock   (CLOCK),
      .rst_n   (RST_N),
      .ch      (ret_ch),
      .send    (1'b1),
      .payload ({c.cmd_seq, read_word}),
      .busy    (ret_busy)
   );

   xfer_rx #(.W(RET_W)) ret_taker (
      .clock (LINK_CLOCK),
      .rst_n (RST_N),
      .ch    (ret_ch),
      .valid (ret_valid),
      .word  (ret_word)
   );

   assign cmd_op   = op_e'(cmd_word[CMD_W-1 -: 2]);
   assign cmd_data = cmd_word[WORD_W-1:0];

   // Register read word by pointer
   always_comb begin
      case (c.ptr)
         PTR_TEMP:   read_word = {c.temp, {TEMP_PAD{1'b0}}};
         PTR_CONFIG: read_word = {{(WORD_W-CFG_W){1'b0}}, c.cfg};
         PTR_HYST:   read_word = {c.hyst, {SP_PAD{1'b0}}};
         default:    read_word = {c.upper, {SP_PAD{1'b0}}};
      endcase
   end

   // Limit comparison on the nine upper bits of the new reading
   always_comb begin
      reading = $signed(CONV_TEMP[TEMP_W-1 -: SP_W]);
      above   = reading > $signed(c.upper);
      below   = reading < $signed(c.hyst);
      trip    = c.hot ? below : above;
      need    = QUEUE_COUNT[c.cfg[CFG_QUEUE_HI:CFG_QUEUE_LO]];
      run_len = QUEUE_W'(c.fault_cnt + 1'b1);
   end

   always_comb begin
      next_c            = c;
      next_c.conv_start = 1'b0;

      // Conversion pacing halts in shutdown
      if (!c.cfg[CFG_SHUTDOWN]) begin
         if (c.conv_cnt == '0) begin
            next_c.conv_start = 1'b1;
            next_c.conv_cnt   = CNT_W'(CONV_CYCLES - 1);
         end else begin
            next_c.conv_cnt = CNT_W'(c.conv_cnt - 1'b1);
         end
      end

      // Host commands; the clear comes first so a trip in the same cycle wins
      if (cmd_valid) begin
         next_c.cmd_seq = ~c.cmd_seq;
         case (cmd_op)
            OP_POINTER: begin
               next_c.ptr = ptr_e'(cmd_data[1:0]);
            end
            OP_WRITE: begin
               case (c.ptr)
                  PTR_CONFIG: begin
                     next_c.cfg = cmd_data[CFG_W-1:0];
                     if (cmd_data[CFG_SHUTDOWN] && !c.cfg[CFG_SHUTDOWN] &&
                         c.cfg[CFG_INT_MODE]) begin
                        next_c.alarm = 1'b0;
                     end
                  end
                  PTR_HYST:  next_c.hyst  = cmd_data[WORD_W-1 -: SP_W];
                  PTR_UPPER: next_c.upper = cmd_data[WORD_W-1 -: SP_W];
                  default:   next_c.temp  = c.temp;
               endcase
            end
            OP_READ: begin
               if (c.cfg[CFG_INT_MODE]) begin
                  next_c.alarm = 1'b0;
               end
            end
            default: next_c.ptr = c.ptr;
         endcase
      end

      // Each done strobe runs one comparison and one filter step
      if (CONV_DONE) begin
         next_c.temp = CONV_TEMP;
         if (trip) begin
            if (run_len >= need) begin
               next_c.hot       = ~c.hot;
               next_c.fault_cnt = '0;
               if (c.cfg[CFG_INT_MODE]) begin
                  next_c.alarm = 1'b1;
               end
            end else begin
               next_c.fault_cnt = run_len;
            end
         end else begin
            next_c.fault_cnt = '0;
         end
      end

      // Comparator behaviour shows the hysteresis state directly
      if (!c.cfg[CFG_INT_MODE]) begin
         next_c.alarm = next_c.hot;
      end
      next_c.pin_en = next_c.alarm ^ next_c.cfg[CFG_POLARITY];
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         c <= CORE_RESET;
      end else begin
         c <= next_c;
      end
   end

   // Link side: one request at a time, busy until its effect is visible
   always_comb begin
      any_req = HOST_PTR_WE | HOST_WE | HOST_RE;
      accept  = any_req & ~l.busy;
      if (HOST_PTR_WE) begin
         cmd_payload = {OP_POINTER, {(WORD_W-2){1'b0}}, HOST_PTR};
      end else if (HOST_WE) begin
         cmd_payload = {OP_WRITE, HOST_WDATA};
      end else begin
         cmd_payload = {OP_READ, {WORD_W{1'b0}}};
      end
   end

   always_comb begin
      next_l = l;
      if (accept) begin
         next_l.issued_seq = ~l.issued_seq;
      end
      if (ret_valid) begin
         next_l.rdata    = ret_word[WORD_W-1:0];
         next_l.seen_seq = ret_word[WORD_W];
      end
      next_l.busy = accept | cmd_busy | (next_l.issued_seq ^ next_l.seen_seq);
   end

   always_ff @(posedge LINK_CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   assign CONV_START            = c.conv_start;
   assign OVERTEMP_ALARM_OUT    = 1'b0;
   assign OVERTEMP_ALARM_OUT_EN = c.pin_en;
   assign HOST_RDATA            = l.rdata;
   assign HOST_BUSY             = l.busy;

   chk_shutdown_no_start: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      c.cfg[CFG_SHUTDOWN] |=> !CONV_START
   ) else $error("conversion started while in shutdown");

   chk_pace_interval: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      CONV_START && !c.cfg[CFG_SHUTDOWN] |=> !CONV_START [*2]
   ) else $error("conversion starts closer than the pacing interval");

   chk_pin_polarity: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $changed(c.cfg[CFG_POLARITY]) && $stable(c.alarm) |-> $changed(OVERTEMP_ALARM_OUT_EN)
   ) else $error("alarm pin level did not follow the polarity bit");

   chk_comp_cause: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $changed(c.alarm) && !c.cfg[CFG_INT_MODE] && !$past(c.cfg[CFG_INT_MODE])
      |-> $past(CONV_DONE)
   ) else $error("comparator alarm changed without a conversion");

   chk_single_trip: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      CONV_DONE && !c.hot && above && c.cfg[CFG_QUEUE_HI:CFG_QUEUE_LO] == 2'b00
      |=> c.hot
   ) else $error("single trip did not flip the alarm state");

   chk_queue_hold: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      CONV_DONE && trip && (run_len < need) |=> $stable(c.hot) && c.fault_cnt == $past(run_len)
   ) else $error("alarm state moved before the trip count was reached");

   chk_queue_clear: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      CONV_DONE && !trip |=> c.fault_cnt == '0 && $stable(c.hot)
   ) else $error("trip counter not cleared by a quiet conversion");

   chk_read_clear: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      cmd_valid && cmd_op == OP_READ && c.cfg[CFG_INT_MODE] && !CONV_DONE |=> !c.alarm
   ) else $error("read did not clear the interrupt alarm");

   chk_setpoint_store: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      cmd_valid && cmd_op == OP_WRITE && c.ptr == PTR_UPPER
      |=> c.upper == $past(cmd_data[WORD_W-1 -: SP_W])
   ) else $error("upper limit not taken from the top nine bits");

   chk_setpoint_pad: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (c.ptr == PTR_HYST || c.ptr == PTR_UPPER) |-> read_word[SP_PAD-1:0] == '0
   ) else $error("set-point read word has nonzero low bits");

   chk_link_busy: assert property (
      @(posedge LINK_CLOCK) disable iff (!RST_N)
      accept |=> HOST_BUSY [*2]
   ) else $error("link took a request without raising busy");

   chk_shutdown_clear: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      cmd_valid && cmd_op == OP_WRITE && c.ptr == PTR_CONFIG && cmd_data[CFG_SHUTDOWN] &&
      !c.cfg[CFG_SHUTDOWN] && c.cfg[CFG_INT_MODE] && !CONV_DONE |=> !c.alarm
   ) else $error("shutdown entry did not clear the interrupt alarm");

   chk_comp_follow: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !c.cfg[CFG_INT_MODE] |=> c.alarm == c.hot
   ) else $error("comparator alarm differs from the hysteresis state");

   chk_temp_capture: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      CONV_DONE |=> c.temp == $past(CONV_TEMP)
   ) else $error("reading not captured with the done strobe");

   chk_pointer_load: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      cmd_valid && cmd_op == OP_POINTER |=> c.ptr == $past(cmd_data[1:0])
   ) else $error("pointer not loaded by a pointer command");
endmodule

// ---- logic/ot_alarm_pkg.sv ----
// Constants, types and operating summary of the over-temperature alarm logic
// Summary of operation
// - Each completed conversion is compared with the upper limit, or with the hysteresis limit while tripped, to update the alarm.
// - Set-points are 16-bit words holding a left-aligned 9-bit signed value, 0.5 degree steps.
// - Only the nine upper bits of the 11-bit reading enter the comparison.
// - Set-point reads return 16 bits with the low seven bits zero.
// - Config bit 2 picks alarm level: one active high, zero active low.
// - Config bit 1 picks interrupt behaviour when one, comparator when zero.
// - Comparator: assert above the upper limit, release only below hysteresis limit.
// - Comparator: host reads and shutdown entry leave the alarm unchanged.
// - Interrupt: trips set the alarm; any read or shutdown entry clears it.
// - Alarm trips only after the selected number of consecutive tripping conversions.
// - Config bits 4:3 give trip counts 1, 2, 4 and 6.
// - Fault filter field is zero after power-up, so one trip suffices.
// - Config bit 0 selects shutdown when one, normal when zero.
// - Shutdown stops new conversions; register access keeps working.
// - Power-up: normal, comparator, active low, pointer zero, limits 80 and 75.
// - Power-on reset returns every register and mode to its default.
// - Two-bit pointer selects reading, configuration, hysteresis or upper limit.
// - Reading is 11-bit signed, 0.125 degree steps, left-aligned, low bits zero.
package ot_alarm_pkg;
   localparam int TEMP_W    = 11;
   localparam int SP_W      = 9;
   localparam int WORD_W    = 16;
   localparam int CFG_W     = 8;
   localparam int SP_PAD    = WORD_W - SP_W;
   localparam int TEMP_PAD  = WORD_W - TEMP_W;
   localparam int TEMP_DROP = TEMP_W - SP_W;
   localparam int QUEUE_W   = 3;

   typedef enum logic [1:0] {
      PTR_TEMP   = 2'b00,
      PTR_CONFIG = 2'b01,
      PTR_HYST   = 2'b10,
      PTR_UPPER  = 2'b11
   } ptr_e;

   typedef enum logic [1:0] {
      OP_POINTER = 2'b00,
      OP_WRITE   = 2'b01,
      OP_READ    = 2'b10
   } op_e;

   localparam int CMD_W = 2 + WORD_W;
   localparam int RET_W = 1 + WORD_W;

   localparam int CFG_SHUTDOWN = 0;
   localparam int CFG_INT_MODE = 1;
   localparam int CFG_POLARITY = 2;
   localparam int CFG_QUEUE_LO = 3;
   localparam int CFG_QUEUE_HI = 4;

   localparam logic [CFG_W-1:0]  CONFIG_RESET = 8'h00;
   localparam logic [SP_W-1:0]   UPPER_RESET  = 9'h0A0;
   localparam logic [SP_W-1:0]   HYST_RESET   = 9'h096;
   localparam logic [TEMP_W-1:0] TEMP_RESET   = 11'h000;
   localparam logic [QUEUE_W-1:0] QUEUE_COUNT [0:3] = '{3'h1, 3'h2, 3'h4, 3'h6};

   localparam int CLOCK_HZ          = 10_000_000;
   localparam int CONV_INTERVAL_MS  = 100;
   localparam int CONV_INTERVAL_CYC = CONV_INTERVAL_MS * (CLOCK_HZ / 1000);
endpackage

// ---- logic/xfer_if.sv ----
// Handshake channel carrying one word between two clock domains
`timescale 1ns/10ps
interface xfer_if #(
   parameter int W = 8
);
   logic [W-1:0] data;
   logic         req;
   logic         ack;

   modport tx (output data, output req, input ack);
   modport rx (input data, input req, output ack);
endinterface

// ---- logic/xfer_tx.sv ----
// Sending end of a toggle handshake word crossing
`timescale 1ns/10ps
module xfer_tx #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   xfer_if.tx                ch,
   input  wire logic         send,
   input  wire logic [W-1:0] payload,
   output var  logic         busy
);
   typedef struct packed {
      logic [W-1:0] data;
      logic         req;
      logic         ack_s1;
      logic         ack_s2;
   } tx_s;

   tx_s s;
   tx_s next_s;

   assign busy    = s.req ^ s.ack_s2;
   assign ch.data = s.data;
   assign ch.req  = s.req;

   // Data is frozen from the toggle until the acknowledge returns
   always_comb begin
      next_s        = s;
      next_s.ack_s1 = ch.ack;
      next_s.ack_s2 = s.ack_s1;
      if (send && !busy) begin
         next_s.data = payload;
         next_s.req  = ~s.req;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- logic/xfer_rx.sv ----
// Receiving end of a toggle handshake word crossing
`timescale 1ns/10ps
module xfer_rx #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   xfer_if.rx                ch,
   output var  logic         valid,
   output var  logic [W-1:0] word
);
   typedef struct packed {
      logic [W-1:0] data;
      logic         req_s1;
      logic         req_s2;
      logic         ack;
      logic         valid;
   } rx_s;

   rx_s s;
   rx_s next_s;

   assign ch.ack = s.ack;
   assign valid  = s.valid;
   assign word   = s.data;

   // Sender holds data stable while the toggles differ
   always_comb begin
      next_s        = s;
      next_s.req_s1 = ch.req;
      next_s.req_s2 = s.req_s1;
      next_s.valid  = 1'b0;
      if (s.req_s2 != s.ack) begin
         next_s.ack   = s.req_s2;
         next_s.data  = ch.data;
         next_s.valid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- verification/host_model.sv ----
// Host controller model issuing pointer, write and read requests on the link
`timescale 1ns/10ps
module host_model (
   input  wire logic        link_clock,
   output var  logic        run,
   output var  logic        ptr_we,
   output var  logic [1:0]  ptr,
   output var  logic        we,
   output var  logic [15:0] wdata,
   output var  logic        re,
   input  wire logic [15:0] rdata,
   input  wire logic        busy
);
   initial begin
      run    = 1'b0;
      ptr_we = 1'b0;
      ptr    = 2'b00;
      we     = 1'b0;
      wdata  = 16'h0000;
      re     = 1'b0;
   end

   // The link clock only runs while a request is in flight or reset is applied
   task automatic req(input logic p_we, input logic w_we, input logic r_re,
                      input logic [1:0] p, input logic [15:0] d, output logic [15:0] q);
      int   n;
      logic seen;
      seen = 1'b0;
      run  = 1'b1;
      @(posedge link_clock);
      #2;
      ptr_we = p_we;
      we     = w_we;
      re     = r_re;
      ptr    = p;
      wdata  = d;
      @(posedge link_clock);
      #2;
      ptr_we = 1'b0;
      we     = 1'b0;
      re     = 1'b0;
      ptr    = ~p;
      wdata  = ~d;
      for (n = 0; n < 40; n++) begin
         @(posedge link_clock);
         #1;
         if (busy === 1'b1) seen = 1'b1;
         else if (seen) break;
      end
      q   = rdata;
      run = 1'b0;
      if (n == 40) overtemp_alarm_logic_tb.conclude(1'b1);
   endtask
endmodule

// ---- verification/overtemp_alarm_logic_tb.sv ----
// Self-checking testbench of the over-temperature alarm logic
`timescale 1ns/10ps
module overtemp_alarm_logic_tb;
   import ot_alarm_pkg::*;
   localparam int          CONV_N = 20;
   localparam logic [10:0] HOT    = 11'h0F8;
   localparam logic [10:0] MID    = 11'h0D8;
   localparam logic [10:0] COLD   = 11'h0C0;
   localparam logic [10:0] EDGE   = 11'h0F2;

   logic        clock;
   logic        rst_n;
   logic        link_clock;
   logic        rst_run;
   logic        run;
   logic        conv_done;
   logic [10:0] conv_temp;
   logic        conv_start;
   logic        ptr_we;
   logic [1:0]  ptr;
   logic        we;
   logic [15:0] wdata;
   logic        re;
   logic [15:0] rdata;
   logic        busy;
   logic        alarm_out;
   logic        en;
   wire logic   pin = en ? alarm_out : 1'b1;
   int          errors;
   int          checks_done;
   int          starts;
   int          cyc;
   int          last;
   int          gap;

   overtemp_alarm_logic #(.CONV_CYCLES(CONV_N)) dut (
      .CLOCK(clock), .RST_N(rst_n), .LINK_CLOCK(link_clock),
      .CONV_DONE(conv_done), .CONV_TEMP(conv_temp), .CONV_START(conv_start),
      .HOST_PTR_WE(ptr_we), .HOST_PTR(ptr), .HOST_WE(we), .HOST_WDATA(wdata),
      .HOST_RE(re), .HOST_RDATA(rdata), .HOST_BUSY(busy),
      .OVERTEMP_ALARM_OUT_LEVEL(pin), .OVERTEMP_ALARM_OUT(alarm_out),
      .OVERTEMP_ALARM_OUT_EN(en)
   );

   host_model host (
      .link_clock(link_clock), .run(run), .ptr_we(ptr_we), .ptr(ptr), .we(we),
      .wdata(wdata), .re(re), .rdata(rdata), .busy(busy)
   );

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      link_clock = 1'b0;
      #13;
      forever begin
         #40;
         if (run || rst_run || link_clock) link_clock = ~link_clock;
      end
   end

   always @(posedge clock) begin
      cyc++;
      if (conv_start === 1'b1) begin
         starts++;
         gap  = cyc - last;
         last = cyc;
      end
   end

   task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_n(input int g, input int e);
      checks_done++;
      if (g != e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Alarm pin enable, checked once any crossing has settled
   task automatic chk_en(input logic e);
      repeat (3) @(posedge clock);
      #2;
      checks_done++;
      if ({pin, en} !== {~e, e}) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, {pin, en}, {~e, e});
      end
   endtask

   task automatic wr(input logic [1:0] p, input logic [15:0] d);
      logic [15:0] q;
      host.req(1'b1, 1'b0, 1'b0, p, {14'h0000, p}, q);
      host.req(1'b0, 1'b1, 1'b0, p, d, q);
   endtask

   task automatic rd(input logic [1:0] p, input logic [15:0] e);
      logic [15:0] q;
      host.req(1'b1, 1'b0, 1'b0, p, {14'h0000, p}, q);
      host.req(1'b0, 1'b0, 1'b1, p, 16'h0000, q);
      cmp_w(q, e);
   endtask

   // One done strobe per reading, the reading invalid between strobes
   task automatic conv(input logic [10:0] t, input int n);
      repeat (n) begin
         @(posedge clock);
         #2;
         conv_done = 1'b1;
         conv_temp = t;
         @(posedge clock);
         #2;
         conv_done = 1'b0;
         conv_temp = ~t;
         repeat (2) @(posedge clock);
      end
   endtask

   task automatic do_reset();
      #2;
      rst_n   = 1'b0;
      rst_run = 1'b1;
      repeat (3) @(posedge clock);
      #2;
      rst_n   = 1'b1;
      rst_run = 1'b0;
   endtask

   task automatic conclude(input bit to);
      if (to) errors++;
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      logic [15:0] q;
      int          s0;
      int          n;
      rst_n       = 1'b0;
      rst_run     = 1'b1;
      conv_done   = 1'b0;
      conv_temp   = 11'h000;
      errors      = 0;
      checks_done = 0;
      starts      = 0;
      cyc         = 0;
      last        = 0;
      gap         = 0;
      do_reset();
      chk_en(1'b0);
      rd(PTR_TEMP, 16'h0000);
      rd(PTR_CONFIG, 16'h0000);
      rd(PTR_HYST, 16'h4B00);
      rd(PTR_UPPER, 16'h5000);
      wr(PTR_HYST, 16'h197F);
      wr(PTR_UPPER, 16'h1E7F);
      rd(PTR_UPPER, 16'h1E00);
      rd(PTR_HYST, 16'h1900);
      conv(EDGE, 1);
      chk_en(1'b0);
      conv(HOT, 1);
      chk_en(1'b1);
      wr(PTR_TEMP, 16'hFFE0);
      rd(PTR_TEMP, 16'h1F00);
      chk_en(1'b1);
      conv(MID, 1);
      chk_en(1'b1);
      conv(COLD, 1);
      chk_en(1'b0);
      for (int k = 0; k < 4; k++) begin
         n = (k == 0) ? 1 : (k == 1) ? 2 : (k == 2) ? 4 : 6;
         wr(PTR_CONFIG, {8'h00, 3'b000, 2'(k), 3'b000});
         conv(HOT, n - 1);
         conv(MID, 1);
         conv(HOT, n - 1);
         chk_en(1'b0);
         conv(HOT, 1);
         chk_en(1'b1);
         conv(COLD, n - 1);
         chk_en(1'b1);
         conv(COLD, 1);
         chk_en(1'b0);
      end
      wr(PTR_CONFIG, 16'h0004);
      chk_en(1'b1);
      conv(HOT, 1);
      chk_en(1'b0);
      conv(COLD, 1);
      wr(PTR_CONFIG, 16'h00E2);
      conv(HOT, 1);
      chk_en(1'b1);
      rd(PTR_CONFIG, 16'h00E2);
      chk_en(1'b0);
      conv(HOT, 1);
      chk_en(1'b0);
      conv(COLD, 1);
      chk_en(1'b1);
      wr(PTR_CONFIG, 16'h0003);
      chk_en(1'b0);
      wr(PTR_CONFIG, 16'h0000);
      conv(HOT, 1);
      chk_en(1'b1);
      wr(PTR_CONFIG, 16'h0001);
      chk_en(1'b1);
      s0 = starts;
      repeat (60) @(posedge clock);
      #2;
      cmp_n(starts - s0, 0);
      rd(PTR_UPPER, 16'h1E00);
      wr(PTR_CONFIG, 16'h0000);
      s0 = starts;
      repeat (60) @(posedge clock);
      #2;
      cmp_n(starts - s0, 3);
      cmp_n(gap, CONV_N);
      conv(COLD, 1);
      chk_en(1'b0);
      conv(HOT, 1);
      rd(PTR_UPPER, 16'h1E00);
      do_reset();
      chk_en(1'b0);
      host.req(1'b0, 1'b0, 1'b1, 2'b00, 16'h0000, q);
      cmp_w(q, 16'h0000);
      rd(PTR_HYST, 16'h4B00);
      rd(PTR_UPPER, 16'h5000);
      conclude(1'b0);
   end
endmodule
